/* rtl/acc_move_op_decoder.sv */
// What this block does
// RULE1: Rotate accumulator left through carry; one byte, one cycle.
// RULE2: Rotate accumulator right through carry; one byte, one cycle.
// RULE3: XOR accumulator into direct byte, write back; two bytes, two cycles.
// RULE4: XOR immediate into direct byte, write back; three bytes, three cycles.
// RULE5: Load accumulator from direct byte; two bytes, two cycles.
// RULE6: Load accumulator from RAM at pointer register; one byte, two cycles.
// RULE7: Copy direct byte into working register; two bytes, two cycles.
// RULE8: Load immediate into working register; two bytes, two cycles.
// RULE9: Store accumulator into direct byte; two bytes, two cycles.
// RULE10: Copy working register into direct byte; two bytes, two cycles.
// RULE11: Zero, invert, plain rotates and nibble swap; one byte, one cycle.
// RULE12: Moves keep carry; carry rotates take carry from bit shifted out.
`timescale 1ns/1ps
`default_nettype none
module acc_move_op_decoder
  import acc_move_pkg::*;
(
  input wire logic clk, // 50 MHz system clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic instr_valid, // Instruction offered this cycle
  input wire instr_t instr, // Opcode plus following bytes
  output logic instr_ready, // Block can take an instruction
  output logic known_op, // Opcode belongs to this block
  output logic [2:0] instr_len, // Instruction length in bytes
  output logic [7:0] mem_rd_addr, // Data memory read address
  input wire logic [7:0] mem_rd_data, // Read data, one cycle later
  output var mem_wr_t mem_wr, // Data memory write port
  input wire logic [7:0] reg_bank [8], // Working registers, live view
  output logic reg_we, // Working register write strobe
  output logic [2:0] reg_sel, // Working register index
  output logic [7:0] reg_wdata, // Working register write data
  output logic [7:0] acc, // Accumulator
  output logic carry, // Carry flag
  output logic done // Pulse as instruction completes
);

  // ------------------------------------------------------------
  // Opcode classes; the multi-cycle ones are shared by the offered and the held opcode
  // ------------------------------------------------------------
  function automatic logic dec_rot_left(
    input logic [7:0] code
  );
    return code == OP_ROT_LEFT;
  endfunction

  function automatic logic dec_rot_left_c(
    input logic [7:0] code
  );
    return code == OP_ROT_LEFT_C;
  endfunction

  function automatic logic dec_rot_right(
    input logic [7:0] code
  );
    return code == OP_ROT_RIGHT;
  endfunction

  function automatic logic dec_rot_right_c(
    input logic [7:0] code
  );
    return code == OP_ROT_RIGHT_C;
  endfunction

  function automatic logic dec_swap(
    input logic [7:0] code
  );
    return code == OP_SWAP;
  endfunction

  function automatic logic dec_zero(
    input logic [7:0] code
  );
    return code == OP_ZERO;
  endfunction

  function automatic logic dec_invert(
    input logic [7:0] code
  );
    return code == OP_INVERT;
  endfunction

  function automatic logic dec_xor_dir_a(
    input logic [7:0] code
  );
    return code == OP_XOR_DIR_A;
  endfunction

  function automatic logic dec_xor_dir_imm(
    input logic [7:0] code
  );
    return code == OP_XOR_DIR_IMM;
  endfunction

  function automatic logic dec_a_from_dir(
    input logic [7:0] code
  );
    return code == OP_A_FROM_DIR;
  endfunction

  function automatic logic dec_dir_from_a(
    input logic [7:0] code
  );
    return code == OP_DIR_FROM_A;
  endfunction

  function automatic logic dec_a_from_ptr(
    input logic [7:0] code
  );
    return code[7:1] == OP_A_FROM_PTR_HI;
  endfunction

  function automatic logic dec_reg_from_dir(
    input logic [7:0] code
  );
    return code[7:3] == OP_REG_FROM_DIR_HI;
  endfunction

  function automatic logic dec_reg_from_imm(
    input logic [7:0] code
  );
    return code[7:3] == OP_REG_FROM_IMM_HI;
  endfunction

  function automatic logic dec_dir_from_reg(
    input logic [7:0] code
  );
    return code[7:3] == OP_DIR_FROM_REG_HI;
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire [7:0] op = instr.opcode;
  wire is_rl = dec_rot_left(op);
  wire is_rlc = dec_rot_left_c(op);
  wire is_rr = dec_rot_right(op);
  wire is_rrc = dec_rot_right_c(op);
  wire is_swap = dec_swap(op);
  wire is_zero = dec_zero(op);
  wire is_inv = dec_invert(op);
  wire is_xda = dec_xor_dir_a(op);
  wire is_xdi = dec_xor_dir_imm(op);
  wire is_adir = dec_a_from_dir(op);
  wire is_dira = dec_dir_from_a(op);
  wire is_aptr = dec_a_from_ptr(op);
  wire is_rdir = dec_reg_from_dir(op);
  wire is_rimm = dec_reg_from_imm(op);
  wire is_dirr = dec_dir_from_reg(op);

  wire single = is_rl | is_rlc | is_rr | is_rrc | is_swap | is_zero | is_inv;
  wire two_cyc = is_xda | is_adir | is_aptr | is_rdir | is_rimm | is_dira
               | is_dirr;

  assign known_op = single | two_cyc | is_xdi;
  assign instr_len = (is_xdi) ? LEN_3 :
                     (is_aptr | single) ? LEN_1 : LEN_2;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  exec_state_t state_ff, nxt_state;
  instr_t held_ff;
  logic [7:0] acc_ff, nxt_acc;
  logic carry_ff, nxt_carry;
  logic [7:0] rd_val_ff;

  assign instr_ready = state_ff == ST_IDLE;
  wire take = instr_valid & instr_ready & known_op;
  wire [7:0] hop = held_ff.opcode;
  wire h_xda = dec_xor_dir_a(hop);
  wire h_xdi = dec_xor_dir_imm(hop);
  wire h_adir = dec_a_from_dir(hop);
  wire h_aptr = dec_a_from_ptr(hop);
  wire h_rdir = dec_reg_from_dir(hop);
  wire h_rimm = dec_reg_from_imm(hop);
  wire h_dira = dec_dir_from_a(hop);
  wire h_dirr = dec_dir_from_reg(hop);

  // Read address issued in the taking cycle; data back in step two
  assign mem_rd_addr = is_aptr ? reg_bank[{2'b00, op[0]}] // see RULE6
                               : instr.byte1;

  // ------------------------------------------------------------
  // Sequencing and accumulator datapath
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_acc = acc_ff;
    nxt_carry = carry_ff; // see RULE12
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          if (is_rlc) begin
            nxt_acc = {acc_ff[6:0], carry_ff}; // see RULE1
            nxt_carry = acc_ff[7]; // see RULE12
          end else if (is_rrc) begin
            nxt_acc = {carry_ff, acc_ff[7:1]}; // see RULE2
            nxt_carry = acc_ff[0]; // see RULE12
          end else if (is_rl) begin
            nxt_acc = {acc_ff[6:0], acc_ff[7]}; // see RULE11
          end else if (is_rr) begin
            nxt_acc = {acc_ff[0], acc_ff[7:1]}; // see RULE11
          end else if (is_swap) begin
            nxt_acc = {acc_ff[3:0], acc_ff[7:4]}; // see RULE11
          end else if (is_zero) begin
            nxt_acc = 8'h00; // see RULE11
          end else if (is_inv) begin
            nxt_acc = ~acc_ff; // see RULE11
          end else begin
            nxt_state = ST_STEP2;
          end
        end
      end
      ST_STEP2: begin
        if (h_adir | h_aptr) begin
          nxt_acc = mem_rd_data; // see RULE5
        end
        // Three-cycle op keeps one more cycle to match timing
        nxt_state = h_xdi ? ST_STEP3 : ST_IDLE; // see RULE4
      end
      ST_STEP3: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      acc_ff <= 8'h00;
      carry_ff <= 1'b0;
      held_ff <= '0;
      rd_val_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      if (take) begin
        held_ff <= instr;
      end
      if (state_ff == ST_STEP2) begin
        rd_val_ff <= mem_rd_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Write-back, registered for clean data outputs
  // ------------------------------------------------------------
  wire in2 = state_ff == ST_STEP2;
  wire in3 = state_ff == ST_STEP3;
  wire [2:0] rsel = hop[2:0];

  mem_wr_t nxt_mem_wr;
  always_comb begin
    nxt_mem_wr = '0;
    if (in2 & h_xda) begin
      nxt_mem_wr = '{1'b1, held_ff.byte1, mem_rd_data ^ acc_ff}; // see RULE3
    end else if (in2 & h_dira) begin
      nxt_mem_wr = '{1'b1, held_ff.byte1, acc_ff}; // see RULE9
    end else if (in2 & h_dirr) begin
      nxt_mem_wr = '{1'b1, held_ff.byte1, reg_bank[rsel]}; // see RULE10
    end else if (in3 & h_xdi) begin
      nxt_mem_wr = '{1'b1, held_ff.byte1,
                     rd_val_ff ^ held_ff.byte2}; // see RULE4
    end
  end

  logic nxt_reg_we;
  logic [7:0] nxt_reg_wdata;
  assign nxt_reg_we = in2 & (h_rdir | h_rimm);
  assign nxt_reg_wdata = h_rdir ? mem_rd_data // see RULE7
                                : held_ff.byte1; // see RULE8

  mem_wr_t mem_wr_ff;
  logic reg_we_ff;
  logic [2:0] reg_sel_ff;
  logic [7:0] reg_wdata_ff;
  logic done_ff;
  wire fin = (take & single) | (in2 & ~h_xdi) | in3;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_wr_ff <= '0;
      reg_we_ff <= 1'b0;
      reg_sel_ff <= 3'h0;
      reg_wdata_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      mem_wr_ff <= nxt_mem_wr;
      reg_we_ff <= nxt_reg_we;
      reg_sel_ff <= rsel;
      reg_wdata_ff <= nxt_reg_wdata;
      done_ff <= fin;
    end
  end

  assign mem_wr = mem_wr_ff;
  assign reg_we = reg_we_ff;
  assign reg_sel = reg_sel_ff;
  assign reg_wdata = reg_wdata_ff;
  assign acc = acc_ff;
  assign carry = carry_ff;
  assign done = done_ff;

endmodule
`default_nettype wire

/* rtl/acc_move_pkg.sv */
package acc_move_pkg;

  // ----------------------------------------------------------------
  // Opcodes of the handled instructions
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ROT_RIGHT = 8'h03;
  localparam logic [7:0] OP_ROT_RIGHT_C = 8'h13;
  localparam logic [7:0] OP_ROT_LEFT = 8'h23;
  localparam logic [7:0] OP_ROT_LEFT_C = 8'h33;
  localparam logic [7:0] OP_XOR_DIR_A = 8'h62;
  localparam logic [7:0] OP_XOR_DIR_IMM = 8'h63;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_ZERO = 8'hE4;
  localparam logic [7:0] OP_INVERT = 8'hF4;
  localparam logic [7:0] OP_A_FROM_DIR = 8'hE5;
  localparam logic [7:0] OP_DIR_FROM_A = 8'hF5;
  // Low-bit groups: bit 0 selects pointer, low 3 bits select register
  localparam logic [6:0] OP_A_FROM_PTR_HI = 7'h73; // 0xE6/0xE7
  localparam logic [4:0] OP_REG_FROM_DIR_HI = 5'h15; // 0xA8..0xAF
  localparam logic [4:0] OP_REG_FROM_IMM_HI = 5'h0F; // 0x78..0x7F
  localparam logic [4:0] OP_DIR_FROM_REG_HI = 5'h11; // 0x88..0x8F

  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STEP2 = 2'b01,
    ST_STEP3 = 2'b11
  } exec_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } instr_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } mem_wr_t;

endpackage

/* sim/acc_move_op_decoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("FAIL %s exp %h got %h", n, e, g); end end
module acc_move_op_decoder_bench;
  import acc_move_pkg::*;
  logic clk = 0, rst_b = 0, instr_valid = 0;
  instr_t instr = '0;
  logic instr_ready, known_op, reg_we, carry, done;
  logic [2:0] instr_len, reg_sel;
  logic [7:0] mem_rd_addr, mem_rd_data = 0, reg_wdata, acc;
  logic [7:0] reg_bank [8];
  logic [7:0] mem [256];
  mem_wr_t mem_wr;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  acc_move_op_decoder dut_u (
    .clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .known_op(known_op),
    .instr_len(instr_len), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr(mem_wr), .reg_bank(reg_bank),
    .reg_we(reg_we), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .acc(acc), .carry(carry), .done(done)
  );
  // ------------------------------
  // Memory, registers, time limit
  // ------------------------------
  always @(posedge clk) begin
    mem_rd_data <= mem[mem_rd_addr];
    if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
    if (reg_we) reg_bank[reg_sel] <= reg_wdata;
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Offers one instruction, checks length and cycles until done
  task automatic run(input logic [7:0] op, b1, b2, input int len, cy);
    int n;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= {op, b1, b2};
    #1 `CHK("len", 3'(len), instr_len)
    @(posedge clk);
    instr_valid <= 1'b0;
    n = 1;
    #1 `CHK("ready", cy == 1, instr_ready)
    while (done !== 1'b1 && n < 9) begin @(posedge clk); #1 n++; end
    `CHK("cycles", cy, n)
  endtask
  task automatic t_rot_carry;
    run(OP_A_FROM_DIR, 8'h10, 0, 2, 2);
    `CHK("acc", 8'h81, acc)
    run(OP_ROT_LEFT_C, 0, 0, 1, 1);
    `CHK("acc c", 9'h102, {carry, acc})
    run(OP_A_FROM_DIR, 8'h10, 0, 2, 2);
    `CHK("acc c", 9'h181, {carry, acc})
    run(OP_ROT_RIGHT_C, 0, 0, 1, 1);
    `CHK("acc c", 9'h1C0, {carry, acc})
    run(OP_ROT_RIGHT_C, 0, 0, 1, 1);
    `CHK("acc c", 9'h0E0, {carry, acc})
  endtask
  task automatic t_acc_ops;
    logic [7:0] ops [6] = '{OP_SWAP, OP_ROT_RIGHT, OP_ROT_RIGHT,
      OP_ROT_LEFT, OP_INVERT, OP_ZERO};
    logic [7:0] ex [6] = '{8'h0E, 8'h07, 8'h83, 8'h07, 8'hF8, 8'h00};
    foreach (ops[i]) begin
      run(ops[i], 0, 0, 1, 1);
      `CHK("acc", ex[i], acc)
    end
  endtask
  task automatic t_xor;
    run(OP_A_FROM_DIR, 8'h21, 0, 2, 2);
    run(OP_XOR_DIR_A, 8'h20, 0, 2, 2);
    `CHK("wr", 17'h1_2055, mem_wr)
    run(OP_XOR_DIR_IMM, 8'h20, 8'hF0, 3, 3);
    `CHK("wr", 17'h1_20A5, mem_wr)
    run(OP_A_FROM_DIR, 8'h20, 0, 2, 2);
    `CHK("acc", 8'hA5, acc)
  endtask
  task automatic t_moves;
    run(8'h7F, 8'h3C, 0, 2, 2);
    `CHK("reg", 12'hF3C, {reg_we, reg_sel, reg_wdata})
    run(8'hA9, 8'h20, 0, 2, 2);
    `CHK("reg", 12'h9A5, {reg_we, reg_sel, reg_wdata})
    run(8'h8F, 8'h31, 0, 2, 2);
    `CHK("wr", 17'h1_313C, mem_wr)
    run(OP_DIR_FROM_A, 8'h30, 0, 2, 2);
    `CHK("wr", 17'h1_30A5, mem_wr)
    run(8'h78, 8'h31, 0, 2, 2);
    run(8'hE6, 0, 0, 1, 2);
    `CHK("acc", 8'h3C, acc)
  endtask
  // Foreign opcode must leave state alone
  task automatic t_refuse;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= {8'hA5, 16'h0000};
    repeat (3) @(posedge clk);
    #1 `CHK("known", 1'b0, known_op)
    `CHK("done", 1'b0, done)
    `CHK("acc", 8'h3C, acc)
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask
  initial begin
    mem[8'h10] = 8'h81;
    mem[8'h20] = 8'h5A;
    mem[8'h21] = 8'h0F;
    foreach (reg_bank[i]) reg_bank[i] = 8'h00;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_rot_carry;
    t_acc_ops;
    t_xor;
    t_moves;
    t_refuse;
    give_verdict;
  end
endmodule
bind acc_move_op_decoder acc_move_sva chk_u (
  .clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .known_op(known_op), .instr_len(instr_len),
  .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr(mem_wr),
  .reg_bank(reg_bank), .reg_we(reg_we), .reg_sel(reg_sel),
  .reg_wdata(reg_wdata), .acc(acc), .carry(carry), .done(done)
);
`default_nettype wire

/* sim/acc_move_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_move_sva
  import acc_move_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic instr_valid, // Offer
  input wire instr_t instr, // Instruction
  input wire logic instr_ready, // Idle
  input wire logic known_op, // Decoded
  input wire logic [2:0] instr_len, // Length
  input wire logic [7:0] mem_rd_addr, // Read address
  input wire logic [7:0] mem_rd_data, // Read data
  input wire mem_wr_t mem_wr, // Write port
  input wire logic [7:0] reg_bank [8], // Registers
  input wire logic reg_we, // Reg strobe
  input wire logic [2:0] reg_sel, // Reg index
  input wire logic [7:0] reg_wdata, // Reg data
  input wire logic [7:0] acc, // Accumulator
  input wire logic carry, // Carry
  input wire logic done // Completion
);
  // ------------------------------
  // Checks per taken instruction
  // ------------------------------
  wire logic take;
  wire logic [7:0] op;
  assign take = instr_valid && instr_ready && known_op;
  assign op = instr.opcode;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_rlc_ring: assert property (
    take && op == OP_ROT_LEFT_C |=> done && carry == $past(acc[7])
    && acc == {$past(acc[6:0]), $past(carry)}) else $error("rlc wrong");
  chk_rrc_ring: assert property (
    take && op == OP_ROT_RIGHT_C |=> done && carry == $past(acc[0])
    && acc == {$past(carry), $past(acc[7:1])}) else $error("rrc wrong");
  chk_xor_dir: assert property (
    take && op == OP_XOR_DIR_A |-> ##2 mem_wr.we && done
    && mem_wr.addr == $past(instr.byte1, 2)
    && mem_wr.data == ($past(mem_rd_data) ^ acc)) else $error("xor a");
  chk_xor_imm: assert property (
    take && op == OP_XOR_DIR_IMM |-> instr_len == LEN_3 ##3 mem_wr.we
    && mem_wr.data == ($past(mem_rd_data, 2) ^ $past(instr.byte2, 3))
    && done) else $error("xor imm");
  chk_load_dir: assert property (
    take && op == OP_A_FROM_DIR |-> ##2 done
    && acc == $past(mem_rd_data)) else $error("load dir");
  chk_ptr_load: assert property (
    take && op[7:1] == OP_A_FROM_PTR_HI |-> instr_len == LEN_1
    && mem_rd_addr == reg_bank[op[0]]
    ##2 done && acc == $past(mem_rd_data)) else $error("ptr load");
  chk_reg_imm: assert property (
    take && op[7:3] == OP_REG_FROM_IMM_HI |-> ##2 reg_we
    && reg_sel == $past(instr.opcode[2:0], 2)
    && reg_wdata == $past(instr.byte1, 2)) else $error("reg imm");
  chk_store_acc: assert property (
    take && op == OP_DIR_FROM_A |-> ##2 mem_wr.we && mem_wr.data == acc
    && carry == $past(carry, 2)) else $error("store acc");
  cover property (take && op == OP_XOR_DIR_IMM);
  cover property (mem_wr.we);
  cover property (reg_we);
endmodule
`default_nettype wire
